// File: src/tifsc_flag_bit.sv
// Purpose: one sticky pending flag with hardware set, software set and clear
// Assumes: all inputs are on core_clk
// Notes: any set outranks a clear in the same cycle
`timescale 1ns/1ns
module tifsc_flag_bit (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic hw_event,
  input  wire logic sw_set,
  input  wire logic sw_clear,
  output logic      flag
);

  logic flag_reg;
  logic flag_next;

  // set wins over clear so a coincident event survives
  always_comb begin
    flag_next = flag_reg;
    if (sw_clear) begin
      flag_next = 1'b0;
    end
    if (sw_set || hw_event) begin
      flag_next = 1'b1;
    end
  end

  // flag register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule

// File: src/tifsc_pkg.sv
// Purpose: shared constants and carrier types for the timer flag set/clear block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: pending flags occupy bits 10:8, 6:4, 1:0 of every flag register
package tifsc_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          FLAG_W          = 11;
  localparam int          SRC_W           = 8;

  // register byte offsets
  localparam logic [7:0]  PENDING_OFFSET  = 8'h10;
  localparam logic [7:0]  SET_OFFSET      = 8'h14;
  localparam logic [7:0]  CLEAR_OFFSET    = 8'h18;

  // flag bit positions
  localparam int          OVF_BIT         = 0;
  localparam int          UNF_BIT         = 1;
  localparam int          CH0_BIT         = 4;
  localparam int          CH1_BIT         = 5;
  localparam int          CH2_BIT         = 6;
  localparam int          OVR0_BIT        = 8;
  localparam int          OVR1_BIT        = 9;
  localparam int          OVR2_BIT        = 10;

  // implemented flag bits; the rest read as zero and ignore writes
  localparam logic [10:0] FLAG_MASK       = 11'h773;
  localparam logic [10:0] FLAG_RESET      = 11'h000;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic        wr_taken;
    logic [7:0]  wr_addr;
    logic        wd_taken;
    logic [31:0] wd_data;
    logic [3:0]  wd_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tifsc_bus_t;

endpackage

// File: src/tifsc_top.sv
// Purpose: pending flag register of a 16-bit timer with set and clear ports on AXI4-Lite
// Assumes: one clock core_clk at 20 MHz; event inputs are one-cycle pulses from core_clk logic
// Notes: write answers two edges after both address and data are in; reads one edge after
//
// How it works
// - a 1 at bit 8, 9 or 10 of the write at 0x014 sets capture overrun flag 0, 1 or 2.
// - a 1 at bit 4, 5 or 6 of the set port sets channel event flag 0, 1 or 2.
// - a 1 at bit 1 of the set port sets the underflow flag.
// - a 1 at bit 0 of the set port sets the overflow flag.
// - a 1 at bit 8, 9 or 10 of the write at 0x018 clears capture overrun flag 0, 1 or 2.
// - a 1 at bit 4, 5 or 6 of the clear port clears channel event flag 0, 1 or 2.
// - a 1 at bit 1 of the clear port clears the underflow flag.
// - a 1 at bit 0 of the clear port clears the overflow flag.
// - the flags are read from a read-only register at 0x010 with the same bit layout.
`timescale 1ns/1ns
module tifsc_top (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // hardware event pulses, same layout as the flag register
  input  wire logic [10:0] hw_event,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pending flags
  output logic [10:0]      pending_flags
);

  tifsc_pkg::tifsc_bus_t st_reg;
  tifsc_pkg::tifsc_bus_t st_next;

  logic [10:0] flag_q;
  logic [10:0] set_pulse;
  logic [10:0] clear_pulse;
  logic [31:0] wr_bits;
  logic        wr_fire;
  logic        aw_ready_c;
  logic        w_ready_c;
  logic        ar_ready_c;
  logic        aw_ready_reg;
  logic        w_ready_reg;
  logic        ar_ready_reg;
  logic [10:0] flags_reg;

  // accept a channel only while its ready output shows high, so a request met by a low
  // ready in the first cycle after reset is never taken behind the master's back
  assign aw_ready_c = aw_ready_reg;
  assign w_ready_c  = w_ready_reg;
  assign ar_ready_c = ar_ready_reg;

  // write commits once both address and data are held
  assign wr_fire = st_reg.wr_taken && st_reg.wd_taken && !st_reg.bvalid;

  // byte lanes without strobe carry no ones; reserved bits dropped
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_bits[i*8 +: 8] = st_reg.wd_strb[i] ? st_reg.wd_data[i*8 +: 8] : 8'h00;
    end
  end

  // one-cycle set and clear pulses; zero bits do nothing
  always_comb begin
    set_pulse   = 11'h000;
    clear_pulse = 11'h000;
    if (wr_fire && st_reg.wr_addr == tifsc_pkg::SET_OFFSET) begin
      set_pulse = wr_bits[10:0] & tifsc_pkg::FLAG_MASK;
    end
    if (wr_fire && st_reg.wr_addr == tifsc_pkg::CLEAR_OFFSET) begin
      clear_pulse = wr_bits[10:0] & tifsc_pkg::FLAG_MASK;
    end
  end

  // one sticky flag per implemented bit
  genvar g;
  generate
    for (g = 0; g < tifsc_pkg::FLAG_W; g++) begin : g_flag
      if (tifsc_pkg::FLAG_MASK[g]) begin : g_impl
        tifsc_flag_bit u_bit (
          .core_clk (core_clk),
          .reset_n  (reset_n),
          .hw_event (hw_event[g]),
          .sw_set   (set_pulse[g]),
          .sw_clear (clear_pulse[g]),
          .flag     (flag_q[g])
        );
      end else begin : g_rsvd
        assign flag_q[g] = 1'b0;
      end
    end
  endgenerate

  // bus state update
  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && aw_ready_c) begin
      st_next.wr_taken = 1'b1;
      st_next.wr_addr  = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && w_ready_c) begin
      st_next.wd_taken = 1'b1;
      st_next.wd_data  = s_axi_wdata;
      st_next.wd_strb  = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_next.wr_taken = 1'b0;
      st_next.wd_taken = 1'b0;
      st_next.bvalid   = 1'b1;
      if (st_reg.wr_addr == tifsc_pkg::SET_OFFSET || st_reg.wr_addr == tifsc_pkg::CLEAR_OFFSET
          || st_reg.wr_addr == tifsc_pkg::PENDING_OFFSET) begin
        st_next.bresp = tifsc_pkg::RESP_OKAY; // flag register ignores writes
      end else begin
        st_next.bresp = tifsc_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && ar_ready_c) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = tifsc_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        tifsc_pkg::PENDING_OFFSET: st_next.rdata = {21'h000000, flag_q};
        tifsc_pkg::SET_OFFSET:     st_next.rdata = 32'h00000000;
        tifsc_pkg::CLEAR_OFFSET:   st_next.rdata = 32'h00000000;
        default: begin
          st_next.rdata = 32'h00000000;
          st_next.rresp = tifsc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // bus state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ready flops mirror the ready terms one cycle ahead
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_ready_reg <= 1'b0;
      w_ready_reg  <= 1'b0;
      ar_ready_reg <= 1'b0;
      flags_reg    <= tifsc_pkg::FLAG_RESET;
    end else begin
      aw_ready_reg <= !st_next.wr_taken && !st_next.bvalid;
      w_ready_reg  <= !st_next.wd_taken && !st_next.bvalid;
      ar_ready_reg <= !st_next.rvalid;
      flags_reg    <= flag_q;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = aw_ready_reg;
  assign s_axi_wready  = w_ready_reg;
  assign s_axi_arready = ar_ready_reg;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign pending_flags = flags_reg;

endmodule

// File: test/tifsc_properties.sv
// Purpose: port properties of the timer flag block
// Assumes: one clock; address and data of a write are offered together
// Notes: pending_flags follows a write three edges after it is taken
`timescale 1ns/1ns
module tifsc_checker (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [10:0] hw_event,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic [10:0] pending_flags
);
  // one clock domain, quiet during reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // full-word write taken at one offset, and a clear with no event beside it
  sequence wr_at(a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb == 4'hf && s_axi_awaddr == a;
  endsequence
  sequence quiet_clr;
    wr_at(8'h18) ##1 hw_event == 11'h000;
  endsequence
  write_answer_a: assert property (wr_at(s_axi_awaddr) |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  flag_set_a: assert property (wr_at(8'h14) |-> ##3
    (~pending_flags & $past(s_axi_wdata[10:0], 3) & tifsc_pkg::FLAG_MASK) == 11'h000)
    else $error("set port missed a flag");
  flag_clear_a: assert property (quiet_clr |-> ##2
    (pending_flags & $past(s_axi_wdata[10:0], 3)) == 11'h000)
    else $error("clear port missed a flag");
  event_set_a: assert property (hw_event != 11'h000 |-> ##2
    (~pending_flags & $past(hw_event, 2) & tifsc_pkg::FLAG_MASK) == 11'h000)
    else $error("event lost");
  read_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hfffff88c) == 32'h0)
    else $error("reserved read bits set");
  flags_mask_a: assert property ((pending_flags & ~tifsc_pkg::FLAG_MASK) == 11'h000)
    else $error("unused flag bit set");
endmodule

// File: test/timer_irq_flag_set_clear_bench.sv
// Purpose: self-checking bench of the timer flag block
// Assumes: full-word writes except two with strobe 4'h1 near the end; model flags kept in m
// Notes: events are driven so they land with the write they follow
`timescale 1ns/1ns
module timer_irq_flag_set_clear_bench;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [10:0] hw_event = 11'h000;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [10:0] pending_flags, d;
  int          errors = 0, checks_done = 0, m = 0, n;
  tifsc_top dut_u (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .hw_event      (hw_event),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pending_flags (pending_flags)
  );
  // free-running clock
  always #25 core_clk = ~core_clk;
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
      begin errors++; $display("MISMATCH %s exp %h got %h", s, e, g); end
  endtask
  task automatic conclude();
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for one of the handshake flags
  task automatic wait_hi(int k);
    logic [3:0] v;
    n = 0;
    do begin
      @(posedge core_clk);
      v = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready && s_axi_wready};
    end while (v[k] !== 1'b1 && ++n < 50);
    if (n >= 50) begin errors++; conclude(); end
  endtask
  // write with an event pulse that meets the flag update
  task automatic wr(logic [7:0] a, logic [10:0] x, logic [10:0] e, logic [1:0] r);
    logic [10:0] y;
    // bits in lanes without strobe count as zero
    y = x & {{3{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    s_axi_awaddr <= a;
    s_axi_wdata <= {21'h0, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_hi(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    hw_event <= e;
    @(posedge core_clk);
    hw_event <= 11'h000;
    wait_hi(1);
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
    if (a == 8'h14) m = m | y;
    if (a == 8'h18) m = m & ~y;
    m = m | e;
    @(posedge core_clk);
  endtask
  // read and compare with the model
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(2);
    s_axi_arvalid <= 1'b0;
    wait_hi(3);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
    chk("pending_flags", m, pending_flags);
    @(posedge core_clk);
  endtask
  // main sequence
  initial begin
    void'($urandom(37));
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h10, 0, 2'h0);
    rd(8'h14, 0, 2'h0);
    rd(8'h18, 0, 2'h0);
    rd(8'h40, 0, 2'h2);
    for (int k = 0; k < 22; k++) begin
      if (tifsc_pkg::FLAG_MASK[k % 11]) begin
        wr(k < 11 ? 8'h14 : 8'h18, 11'h1 << (k % 11), 0, 0);
        rd(8'h10, m, 2'h0);
      end
    end
    repeat (30) begin
      d = 11'($urandom) & tifsc_pkg::FLAG_MASK;
      wr($urandom % 2 ? 8'h14 : 8'h18, d, 11'($urandom) & 11'($urandom) & d, 0);
      rd(8'h10, m, 2'h0);
    end
    wr(8'h10, ~11'(m) & tifsc_pkg::FLAG_MASK, 0, 0);
    wr(8'h40, 11'h001, 0, 2'h2);
    s_axi_wstrb <= 4'h1;
    @(posedge core_clk);
    wr(8'h14, 11'h773, 0, 0);
    wr(8'h18, 11'h773, 0, 0);
    s_axi_wstrb <= 4'hf;
    @(posedge core_clk);
    rd(8'h10, m, 2'h0);
    conclude();
  end
endmodule
bind tifsc_top tifsc_checker chk_u (.*);
